// file: smb_access_consts.svh
// Register offsets, field positions, reset values and link constants of the SMBus access block.
`ifndef SMB_ACCESS_CONSTS_SVH
`define SMB_ACCESS_CONSTS_SVH

`define EE_ACCESS_OFF 12'h34C
`define XP_ACCESS_OFF 12'h350
`define IRQ_STATUS_OFF 12'h380
`define IRQ_CLEAR_OFF 12'h384
`define IRQ_ENABLE_OFF 12'h388

`define EE_KIND_BIT 26
`define EE_DONE_BIT 25
`define XP_REFRESH_BIT 24
`define XP_MODE_BIT 25
`define XP_DONE_BIT 31

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define KIND_EE_WRITE 2'h0
`define KIND_EE_READ 2'h1
`define KIND_XP_REFRESH 2'h2
`define KIND_XP_UPDATE 2'h3

`define TX_BITS 6'h20
`define RX_BITS 6'h10
`define OUT_MASK_RESET 16'hFF00

`endif

// file: smb_access_pkg.sv
// Types shared by the SMBus access block and its link helpers.
package smb_access_pkg;

	typedef enum logic [1:0] {LS_IDLE, LS_ARM, LS_SEND, LS_RECV} link_state_t;

	typedef struct packed {
		logic [1:0] clk_sync;
		logic clk_prev;
		logic [1:0] data_sync;
		logic rise;
		logic fall;
	} edge_state_t;

	typedef struct packed {
		link_state_t state;
		logic [5:0] count;
		logic [31:0] shift;
		logic [15:0] rx;
		logic done;
		logic data_oe;
	} shifter_state_t;

	typedef struct packed {
		logic aw_got;
		logic [11:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] ee_addr;
		logic [7:0] ee_data;
		logic ee_kind;
		logic ee_op;
		logic ee_busy;
		logic ee_done;
		logic ee_pend;
		logic xp_mode;
		logic [3:0] xp_sel;
		logic xp_done;
		logic xp_pend;
		logic xp_update;
		logic [1:0] xp_slot;
		logic [15:0] xp_override;
		logic [3:0][15:0] pins_in;
		logic [3:0][15:0] pins_out;
		logic link_start;
		logic link_active;
		logic link_owner;
		logic [1:0] link_slot;
		logic [31:0] link_tx;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic irq;
	} access_state_t;

endpackage

// file: link_edge_detect.sv
// Synchronises the link clock and data pin and finds the link clock edges.
`timescale 1ns/1ps
module link_edge_detect (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Pins from the link
	input wire logic link_clk,
	input wire logic data_in,
	// Synchronised view
	output logic link_rise,
	output logic link_fall,
	output logic data_sync
);
	smb_access_pkg::edge_state_t st;
	smb_access_pkg::edge_state_t next_st;

	// The first stage of each synchroniser feeds only the second stage.
	always_comb begin
		next_st = st;
		next_st.clk_sync = {st.clk_sync[0], link_clk};
		next_st.data_sync = {st.data_sync[0], data_in};
		next_st.clk_prev = st.clk_sync[1];
		next_st.rise = st.clk_sync[1] && !st.clk_prev;
		next_st.fall = !st.clk_sync[1] && st.clk_prev;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// Both pins idle high, so the synchronisers start there and reset release shows no edge.
			st <= '{clk_sync: 2'b11, clk_prev: 1'b1, data_sync: 2'b11, rise: 1'b0, fall: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign link_rise = st.rise;
	assign link_fall = st.fall;
	assign data_sync = st.data_sync[1];
endmodule

// file: smb_frame_shifter.sv
// Shifts one command frame out and one answer frame in over the open-drain data pin.
`timescale 1ns/1ps
`include "smb_access_consts.svh"
module smb_frame_shifter #(
	parameter logic [5:0] TX_BITS = `TX_BITS,
	parameter logic [5:0] RX_BITS = `RX_BITS
) (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Link edges and sampled data
	input wire logic link_rise,
	input wire logic link_fall,
	input wire logic data_sync,
	// Frame request and answer
	input wire logic start,
	input wire logic [31:0] tx_frame,
	output logic busy,
	output logic done,
	output logic [15:0] rx_frame,
	// Open-drain data pin
	output logic data_out,
	output logic data_oe
);
	smb_access_pkg::shifter_state_t st;
	smb_access_pkg::shifter_state_t next_st;

	// Bits change on falling link edges so the partner samples them stable on rising edges.
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		unique case (st.state)
			smb_access_pkg::LS_IDLE: begin
				if (start) begin
					next_st.shift = tx_frame;
					next_st.state = smb_access_pkg::LS_ARM;
				end
			end
			smb_access_pkg::LS_ARM: begin
				if (link_fall) begin
					next_st.data_oe = 1'b1;
					next_st.count = 6'h00;
					next_st.state = smb_access_pkg::LS_SEND;
				end
			end
			smb_access_pkg::LS_SEND: begin
				if (link_fall) begin
					if (st.count == TX_BITS) begin
						next_st.data_oe = 1'b0;
						next_st.count = 6'h00;
						next_st.state = smb_access_pkg::LS_RECV;
					end else begin
						next_st.data_oe = !st.shift[31];
						next_st.shift = {st.shift[30:0], 1'b0};
						next_st.count = st.count + 6'h01;
					end
				end
			end
			smb_access_pkg::LS_RECV: begin
				if (link_rise) begin
					next_st.rx = {st.rx[14:0], data_sync};
					next_st.count = st.count + 6'h01;
					if (st.count == RX_BITS - 6'h01) begin
						next_st.done = 1'b1;
						next_st.state = smb_access_pkg::LS_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign busy = (st.state != smb_access_pkg::LS_IDLE);
	assign done = st.done;
	assign rx_frame = st.rx;
	assign data_out = 1'b0;
	assign data_oe = st.data_oe;
endmodule

// file: smb_access_regs.sv
// AXI4-Lite register bank for EEPROM byte access and expander pin mirroring.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "smb_access_consts.svh"
module smb_access_regs #(
	parameter logic [15:0] OUT_MASK = `OUT_MASK_RESET
) (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// AXI4-Lite write address and data
	input wire logic [11:0] axi_awaddr,
	input wire logic axi_awvalid,
	output logic axi_awready,
	input wire logic [31:0] axi_wdata,
	input wire logic [3:0] axi_wstrb,
	input wire logic axi_wvalid,
	output logic axi_wready,
	// AXI4-Lite write response
	output logic [1:0] axi_bresp,
	output logic axi_bvalid,
	input wire logic axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] axi_araddr,
	input wire logic axi_arvalid,
	output logic axi_arready,
	output logic [31:0] axi_rdata,
	output logic [1:0] axi_rresp,
	output logic axi_rvalid,
	input wire logic axi_rready,
	// Expander output values from core logic, one word per expander slot
	input wire logic [3:0][15:0] core_out,
	// Serial link
	input wire logic link_clk,
	input wire logic link_data_in,
	output logic link_data_out,
	output logic link_data_oe,
	// Interrupt
	output logic irq
);
	smb_access_pkg::access_state_t st;
	smb_access_pkg::access_state_t next_st;
	logic link_rise;
	logic link_fall;
	logic data_sync;
	logic link_busy;
	logic link_done;
	logic [15:0] link_rx;
	logic kind_now;
	logic [2:0] slot;
	logic [15:0] out_val;
	logic [31:0] d;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------

	// Returns {valid, slot}; expander 4 lives in slot 3.
	function automatic logic [2:0] slot_of(input logic [3:0] sel);
		logic [2:0] r;
		r = 3'h0;
		unique case (sel)
			4'h0: r = 3'h4;
			4'h1: r = 3'h5;
			4'h2: r = 3'h6;
			4'h4: r = 3'h7;
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	// Input bits show what was fetched, output bits what was last supplied.
	function automatic logic [15:0] pin_view(input smb_access_pkg::access_state_t s, input logic [1:0] idx);
		return (s.pins_in[idx] & ~OUT_MASK) | (s.pins_out[idx] & OUT_MASK);
	endfunction

	function automatic logic [33:0] read_word(input smb_access_pkg::access_state_t s, input logic [11:0] addr);
		logic [2:0] sl;
		logic [15:0] view;
		logic [33:0] r;
		sl = slot_of(s.xp_sel);
		view = sl[2] ? pin_view(s, sl[1:0]) : 16'h0000;
		r = {`RESP_OKAY, 32'h0000_0000};
		unique case (addr)
			`EE_ACCESS_OFF: r[31:0] = {5'h00, s.ee_kind, s.ee_done, s.ee_busy, s.ee_data, s.ee_addr};
			`XP_ACCESS_OFF: r[31:0] = {s.xp_done, 1'b0, s.xp_sel, s.xp_mode, 1'b0, 8'h00, view};
			`IRQ_STATUS_OFF: r[31:0] = {30'h0000_0000, s.irq_status};
			`IRQ_CLEAR_OFF: r[31:0] = 32'h0000_0000;
			`IRQ_ENABLE_OFF: r[31:0] = {30'h0000_0000, s.irq_enable};
			default: r[33:32] = `RESP_SLVERR;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Frame builders
	// ----------------------------------------------------------------

	// EEPROM command word: kind, six spare bits, byte address, data byte.
	function automatic logic [31:0] ee_frame(input logic rd_kind, input logic [15:0] addr, input logic [7:0] data);
		logic [1:0] kind;
		kind = rd_kind ? `KIND_EE_READ : `KIND_EE_WRITE;
		return {kind, 6'h00, addr, data};
	endfunction

	// Expander command word: kind, two spare bits, select code, output values and a spare byte.
	// The low byte stays zero because the answer, not the command, carries the input pins.
	function automatic logic [31:0] xp_frame(input logic update, input logic [3:0] sel, input logic [15:0] outs);
		logic [1:0] kind;
		kind = update ? `KIND_XP_UPDATE : `KIND_XP_REFRESH;
		return {kind, 2'h0, sel, outs, 8'h00};
	endfunction

	// ----------------------------------------------------------------
	// Link helpers
	// ----------------------------------------------------------------

	link_edge_detect edges (
		.clk(clk),
		.sys_rst(sys_rst),
		.link_clk(link_clk),
		.data_in(link_data_in),
		.link_rise(link_rise),
		.link_fall(link_fall),
		.data_sync(data_sync)
	);

	smb_frame_shifter shifter (
		.clk(clk),
		.sys_rst(sys_rst),
		.link_rise(link_rise),
		.link_fall(link_fall),
		.data_sync(data_sync),
		.start(st.link_start),
		.tx_frame(st.link_tx),
		.busy(link_busy),
		.done(link_done),
		.rx_frame(link_rx),
		.data_out(link_data_out),
		.data_oe(link_data_oe)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// Software accesses are applied first and hardware events last, so a flag that sets
	// in the same cycle as its clear stays set.
	always_comb begin
		next_st = st;
		kind_now = st.ee_kind;
		slot = slot_of(st.xp_sel);
		out_val = 16'h0000;
		d = st.w_data;
		next_st.link_start = 1'b0;

		// ------------------------------------------------------------
		// Write address and data capture
		// ------------------------------------------------------------
		if (axi_awvalid && st.awready) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = {axi_awaddr[11:2], 2'b00};
		end
		if (axi_wvalid && st.wready) begin
			next_st.w_got = 1'b1;
			next_st.w_data = axi_wdata;
			next_st.w_strb = axi_wstrb;
		end
		if (st.bvalid && axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// ------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------
		// A write is applied only once its response can be issued, so a held B never loses one.
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `RESP_OKAY;
			unique case (st.aw_addr)
				`EE_ACCESS_OFF: begin
					if (st.w_strb[0]) begin
						next_st.ee_addr[7:0] = d[7:0];
					end
					if (st.w_strb[1]) begin
						next_st.ee_addr[15:8] = d[15:8];
					end
					if (st.w_strb[3]) begin
						kind_now = d[`EE_KIND_BIT];
						next_st.ee_kind = d[`EE_KIND_BIT];
						if (d[`EE_DONE_BIT]) begin
							next_st.ee_done = 1'b0;
						end
					end
					// A launch while busy is dropped whole; the byte in flight is kept.
					if (st.w_strb[2] && !st.ee_busy) begin
						next_st.ee_pend = 1'b1;
						next_st.ee_busy = 1'b1;
						next_st.ee_op = kind_now;
						if (!kind_now) begin
							next_st.ee_data = d[23:16];
						end
					end
				end
				`XP_ACCESS_OFF: begin
					if (st.w_strb[3]) begin
						if (d[`XP_DONE_BIT]) begin
							next_st.xp_done = 1'b0;
						end
						next_st.xp_mode = d[`XP_MODE_BIT];
						next_st.xp_sel = d[29:26];
					end
					slot = slot_of(next_st.xp_sel);
					if (st.w_strb[3] && d[`XP_REFRESH_BIT] && slot[2] && !st.xp_pend) begin
						next_st.xp_pend = 1'b1;
						next_st.xp_update = 1'b0;
						next_st.xp_slot = slot[1:0];
					end
					if ((st.w_strb[0] || st.w_strb[1]) && next_st.xp_mode && slot[2]) begin
						if (st.w_strb[0]) begin
							next_st.xp_override[7:0] = d[7:0];
						end
						if (st.w_strb[1]) begin
							next_st.xp_override[15:8] = d[15:8];
						end
						if (!next_st.xp_pend) begin
							next_st.xp_pend = 1'b1;
							next_st.xp_update = 1'b1;
							next_st.xp_slot = slot[1:0];
						end
					end
				end
				`IRQ_CLEAR_OFF: begin
					if (st.w_strb[0]) begin
						next_st.irq_status = st.irq_status & ~d[1:0];
					end
				end
				`IRQ_ENABLE_OFF: begin
					if (st.w_strb[0]) begin
						next_st.irq_enable = d[1:0];
					end
				end
				`IRQ_STATUS_OFF: begin
					next_st.bresp = `RESP_OKAY;
				end
				default: begin
					next_st.bresp = `RESP_SLVERR;
				end
			endcase
		end

		// ------------------------------------------------------------
		// Read channel
		// ------------------------------------------------------------
		if (st.rvalid && axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (axi_arvalid && st.arready) begin
			{next_st.rresp, next_st.rdata} = read_word(st, {axi_araddr[11:2], 2'b00});
			next_st.rvalid = 1'b1;
		end

		// ------------------------------------------------------------
		// Link arbitration
		// ------------------------------------------------------------
		// One link serves both services; the EEPROM wins when both wait.
		// The shifter's own busy is checked too, so no request starts while a frame still drains.
		if (!st.link_active && !link_busy) begin
			if (st.ee_pend) begin
				next_st.ee_pend = 1'b0;
				next_st.link_start = 1'b1;
				next_st.link_active = 1'b1;
				next_st.link_owner = 1'b0;
				next_st.link_tx = ee_frame(st.ee_op, st.ee_addr, st.ee_data);
			end else if (st.xp_pend) begin
				out_val = (st.xp_mode ? st.xp_override : core_out[st.xp_slot]) & OUT_MASK;
				next_st.xp_pend = 1'b0;
				next_st.link_start = 1'b1;
				next_st.link_active = 1'b1;
				next_st.link_owner = 1'b1;
				next_st.link_slot = st.xp_slot;
				next_st.pins_out[st.xp_slot] = out_val;
				next_st.link_tx = xp_frame(st.xp_update, st.xp_sel, out_val);
			end
		end

		// ------------------------------------------------------------
		// Completion
		// ------------------------------------------------------------
		// Completion counts only after the start pulse, so an old done is never credited to a new frame.
		if (st.link_active && !st.link_start && link_done) begin
			next_st.link_active = 1'b0;
			if (!st.link_owner) begin
				next_st.ee_busy = 1'b0;
				next_st.ee_done = 1'b1;
				next_st.irq_status[0] = 1'b1;
				if (st.ee_op) begin
					next_st.ee_data = link_rx[7:0];
				end
			end else begin
				next_st.pins_in[st.link_slot] = link_rx;
				next_st.xp_done = 1'b1;
				next_st.irq_status[1] = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// Handshake outputs
		// ------------------------------------------------------------
		// AW and W readies follow the capture flags and AR ready follows rvalid, so no address or word is taken twice before its response.
		next_st.awready = !next_st.aw_got;
		next_st.wready = !next_st.w_got;
		next_st.arready = !next_st.rvalid;
		next_st.irq = |(next_st.irq_status & next_st.irq_enable);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	assign axi_awready = st.awready;
	assign axi_wready = st.wready;
	assign axi_bresp = st.bresp;
	assign axi_bvalid = st.bvalid;
	assign axi_arready = st.arready;
	assign axi_rdata = st.rdata;
	assign axi_rresp = st.rresp;
	assign axi_rvalid = st.rvalid;
	assign irq = st.irq;
endmodule

// file: smb_access_chk.sv
// Port-level assertions for the SMBus access register block.
`timescale 1ns/1ps
module smb_access_chk (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// AXI4-Lite
	input wire logic [11:0] axi_awaddr,
	input wire logic axi_awvalid,
	input wire logic axi_awready,
	input wire logic [31:0] axi_wdata,
	input wire logic [3:0] axi_wstrb,
	input wire logic axi_wvalid,
	input wire logic axi_wready,
	input wire logic axi_bvalid,
	input wire logic [11:0] axi_araddr,
	input wire logic axi_arvalid,
	input wire logic axi_arready,
	input wire logic [31:0] axi_rdata,
	input wire logic axi_rvalid,
	// Link
	input wire logic link_data_oe
);
	// Address and word of the last accepted transfers, so that answers can be tied to their request.
	logic [11:0] wa;
	logic [11:0] ra;
	logic [31:0] wd;
	logic [3:0] ws;
	always_ff @(posedge clk) begin
		if (axi_awvalid && axi_awready)
			wa <= axi_awaddr;
		if (axi_wvalid && axi_wready)
			wd <= axi_wdata;
		if (axi_wvalid && axi_wready)
			ws <= axi_wstrb;
		if (axi_arvalid && axi_arready)
			ra <= axi_araddr;
	end
	wire ee_rd = axi_rvalid && ra == 12'h034C;
	wire xp_rd = axi_rvalid && ra == 12'h0350;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_frame;
		$rose(link_data_oe);
	endsequence
	sequence s_ee_go;
		$rose(axi_bvalid) && wa == 12'h034C && ws[2];
	endsequence
	sequence s_xp_go;
		$rose(axi_bvalid) && wa == 12'h0350 && ws[3] && wd[24] && wd[29:26] inside {4'h0, 4'h1, 4'h2, 4'h4};
	endsequence
	property p_ee_launch;
		s_ee_go |-> ##[0:600] s_frame;
	endproperty
	a_ee_launch: assert property (p_ee_launch) else $error("no frame after launch");
	property p_xp_refresh;
		s_xp_go |-> ##[0:600] s_frame;
	endproperty
	a_xp_refresh: assert property (p_xp_refresh) else $error("no frame after refresh");
	property p_ee_resv;
		ee_rd |-> axi_rdata[31:27] == 5'h00;
	endproperty
	a_ee_resv: assert property (p_ee_resv) else $error("eeprom spare bits set");
	property p_xp_resv;
		xp_rd |-> !axi_rdata[30] && axi_rdata[23:16] == 8'h00;
	endproperty
	a_xp_resv: assert property (p_xp_resv) else $error("expander spare bits set");
	property p_refresh_zero;
		xp_rd |-> !axi_rdata[24];
	endproperty
	a_refresh_zero: assert property (p_refresh_zero) else $error("refresh bit read one");
	property p_resv_sel;
		xp_rd && !(axi_rdata[29:26] inside {4'h0, 4'h1, 4'h2, 4'h4}) |-> axi_rdata[15:0] == 16'h0000;
	endproperty
	a_resv_sel: assert property (p_resv_sel) else $error("pins shown for spare select");
	property p_b_after;
		$rose(axi_bvalid) |-> !$past(axi_awready) && !$past(axi_wready);
	endproperty
	a_b_after: assert property (p_b_after) else $error("response before both taken");
	property p_ar_block;
		axi_rvalid |-> !axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
endmodule
bind smb_access_regs smb_access_chk chk_i (.*);

// file: smb_far_end.sv
// Behavioural serial EEPROM and I/O expanders at the far end of the link.
`timescale 1ns/1ps
module smb_far_end (
	// Link pins
	output logic link_clk,
	input wire logic link_data_oe,
	output logic link_data_in,
	// Bench view
	input wire logic [15:0] exp_in,
	output logic [31:0] last_cmd,
	output int frames
);
	logic [7:0] mem [0:65535];
	logic [31:0] cmd;
	logic [15:0] ans;
	logic pull = 0;
	// The line has a pull-up, so once both sides let go it reads high, never a stale bit.
	assign link_data_in = !(link_data_oe || pull);
	initial begin
		link_clk = 0;
		forever #100 link_clk = ~link_clk;
	end
	// ----------------------------------------
	// Frame decoder
	// ----------------------------------------
	initial begin
		frames = 0;
		forever begin
			@(posedge link_clk);
			if (link_data_in === 1'b0) begin
				repeat (32) begin
					@(posedge link_clk);
					cmd = {cmd[30:0], link_data_in};
				end
				last_cmd = cmd;
				frames++;
				ans = exp_in;
				if (cmd[31:30] == 2'h0)
					mem[cmd[23:8]] = cmd[7:0];
				if (cmd[31:30] == 2'h1)
					ans = {8'h00, mem[cmd[23:8]]};
				for (int i = 15; i >= 0; i--) begin
					@(negedge link_clk);
					pull = !ans[i];
				end
				@(negedge link_clk);
				pull = 0;
			end
		end
	end
endmodule

// file: smb_eeprom_expander_access_bench.sv
// Self-checking bench for the SMBus access register block.
`timescale 1ns/1ps
module smb_eeprom_expander_access_bench;
	logic clk;
	logic sys_rst = 1;
	logic [11:0] axi_awaddr = '0, axi_araddr = '0;
	logic [31:0] axi_wdata = '0, axi_rdata, last_cmd;
	logic [3:0] axi_wstrb = '0;
	logic axi_awvalid = 0, axi_wvalid = 0, axi_bready = 0, axi_arvalid = 0, axi_rready = 0;
	logic axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid;
	logic [1:0] axi_bresp, axi_rresp;
	logic link_clk, link_data_in, link_data_out, link_data_oe, irq;
	logic [3:0][15:0] core_out = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
	logic [15:0] exp_in = 16'hA5C3;
	int err_count = 0, num_checks = 0, cyc = 0, frames;
	smb_access_regs uut (.*);
	smb_far_end far (.*);
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r = 2'h0);
		@(posedge clk);
		axi_awaddr <= a;
		axi_wdata <= d;
		axi_wstrb <= s;
		axi_awvalid <= 1;
		axi_wvalid <= 1;
		axi_bready <= 1;
		do begin
			@(posedge clk);
			if (axi_awready)
				axi_awvalid <= 0;
			if (axi_wready)
				axi_wvalid <= 0;
		end while (axi_bvalid !== 1'b1);
		axi_bready <= 0;
		chk("bresp", axi_bresp, r);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		axi_araddr <= a;
		axi_arvalid <= 1;
		axi_rready <= 1;
		do begin
			@(posedge clk);
			if (axi_arready)
				axi_arvalid <= 0;
		end while (axi_rvalid !== 1'b1);
		d = axi_rdata;
		r = axi_rresp;
		axi_rready <= 0;
	endtask
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(n, d, e);
	endtask
	// Polls until a completion bit reads one; the cycle ceiling cuts a hang short.
	task automatic wait_set(input logic [11:0] a, input int b);
		logic [31:0] d;
		logic [1:0] r;
		do rd(a, d, r); while (d[b] !== 1'b1);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rchk("eeprom reg", 12'h34C, 32'h0000_0000);
		rchk("expander reg", 12'h350, 32'h0000_0000);
		wr(12'h380, 32'hFFFF_FFFF, 4'hF);
		rchk("status", 12'h380, 32'h0000_0000);
		wr(12'h3F0, 32'hFFFF_FFFF, 4'hF, 2'h2);
		rd(12'h3F0, d, r);
		chk("unmapped resp", r, 2'h2);
		chk("unmapped data", d, 32'h0000_0000);
		$display("reset test done");
	endtask
	task automatic t_ee_write;
		wr(12'h34C, 32'h005A_FFFF, 4'hF);
		rchk("busy", 12'h34C, 32'h015A_FFFF);
		wait_set(12'h34C, 25);
		chk("write frame", last_cmd, 32'h00FF_FF5A);
		chk("stored byte", far.mem[16'hFFFF], 8'h5A);
		rchk("done", 12'h34C, 32'h025A_FFFF);
		wr(12'h388, 32'h0000_0003, 4'hF);
		rchk("status", 12'h380, 32'h0000_0001);
		chk("irq up", irq, 1'b1);
		wr(12'h384, 32'h0000_0001, 4'hF);
		rchk("status", 12'h380, 32'h0000_0000);
		chk("irq down", irq, 1'b0);
		wr(12'h34C, 32'h0200_0000, 4'h8);
		rchk("done clear", 12'h34C, 32'h005A_FFFF);
		$display("eeprom write test done");
	endtask
	task automatic t_ee_read;
		wr(12'h34C, 32'h0096_0010, 4'hF);
		wait_set(12'h34C, 25);
		chk("second byte", far.mem[16'h0010], 8'h96);
		wr(12'h34C, 32'h0600_FFFF, 4'hB);
		wr(12'h34C, 32'h00C3_0000, 4'h4);
		wait_set(12'h34C, 25);
		chk("read frame", last_cmd, 32'h40FF_FF96);
		chk("byte kept", far.mem[16'hFFFF], 8'h5A);
		rchk("read data", 12'h34C, 32'h065A_FFFF);
		chk("irq again", irq, 1'b1);
		wr(12'h388, 32'h0000_0000, 4'hF);
		rchk("status", 12'h380, 32'h0000_0001);
		chk("irq masked", irq, 1'b0);
		$display("eeprom read test done");
	endtask
	task automatic t_expander;
		wr(12'h350, 32'h0000_FFFF, 4'h3);
		rchk("pins locked", 12'h350, 32'h0000_0000);
		wr(12'h350, 32'h0500_0000, 4'h8);
		wait_set(12'h350, 31);
		chk("refresh frame", last_cmd[31:8], 24'h81_2200);
		rchk("pin view", 12'h350, 32'h8400_22C3);
		wr(12'h350, 32'h8600_0000, 4'h8);
		wr(12'h350, 32'h0000_9876, 4'h3);
		wait_set(12'h350, 31);
		chk("update frame", last_cmd[31:8], 24'hC1_9800);
		rchk("override view", 12'h350, 32'h8600_98C3);
		rchk("status both", 12'h380, 32'h0000_0003);
		chk("data out", link_data_out, 1'b0);
		$display("expander test done");
	endtask
	task automatic t_reserved;
		int f;
		wr(12'h350, 32'h8C00_0000, 4'h8);
		rchk("spare view", 12'h350, 32'h0C00_0000);
		f = frames;
		wr(12'h350, 32'h0D00_0000, 4'h8);
		wr(12'h350, 32'h1100_0000, 4'h8);
		wait_set(12'h350, 31);
		chk("frame count", frames, f + 1);
		chk("select four", last_cmd[27:24], 4'h4);
		chk("select four out", last_cmd[23:8], 16'h4400);
		$display("select test done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		t_reset();
		t_ee_write();
		t_ee_read();
		t_expander();
		t_reserved();
		stop_test();
	end
endmodule
